// [hdl/scm_defs.vh]
// Constants for the capture and chip mode register group
`ifndef SCM_DEFS_VH
`define SCM_DEFS_VH

// ****************************************************************
// Register addresses (15-bit serial port address)
// ****************************************************************
`define SCM_ADDR_W            15
`define SCM_ADDR_SKIP         15'h0121
`define SCM_ADDR_TS_DELAY     15'h0123
`define SCM_ADDR_WIN_STATUS   15'h0128
`define SCM_ADDR_PHASE        15'h0129
`define SCM_ADDR_CAP_COUNT    15'h012A
`define SCM_ADDR_SYNC_MODE    15'h01FF
`define SCM_ADDR_APP_MODE     15'h0200
`define SCM_ADDR_DECIM        15'h0201
`define SCM_ADDR_OFFSET       15'h0228

// ****************************************************************
// Reset values
// ****************************************************************
`define SCM_RST_SKIP          4'h0
`define SCM_RST_TS_DELAY      7'h00
`define SCM_RST_SYNC_MODE     2'h0
`define SCM_RST_OP_MODE       2'h0
`define SCM_RST_QDROP         1'b0
`define SCM_RST_DECIM         3'h0
`define SCM_RST_OFFSET        8'h00

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define SCM_APP_QDROP_BIT     5
`define SCM_SYNC_TIMESTAMP    2'h1
`define SCM_OP_FULL_BW        2'h0
`define SCM_OP_DDC0           2'h1
`define SCM_OP_DDC01          2'h2
`define SCM_OP_DDC0123        2'h3
`define SCM_DEC_1             3'h0
`define SCM_DEC_2             3'h1
`define SCM_DEC_4             3'h2
`define SCM_DEC_8             3'h3

// ****************************************************************
// Serial port framing
// ****************************************************************
`define SCM_INSTR_LAST        5'h0F
`define SCM_DATA_LAST         5'h17
`define SCM_FRAME_DONE        5'h18

`endif

// [hdl/scm_spi_slave.v]
// Serial control port slave: 16-bit instruction then one data byte
`default_nettype none
`include "scm_defs.vh"

module scm_spi_slave (
   input  wire                     i_core_clk,
   input  wire                     i_rst,
   input  wire                     i_sclk,
   input  wire                     i_csb_n,
   input  wire                     i_sdio,
   output reg                      o_sdio,
   output reg                      o_sdio_oe_n,
   output reg                      o_wr_stb,
   output reg                      o_rd_stb,
   output reg  [`SCM_ADDR_W-1:0]   o_addr,
   output reg  [7:0]               o_wdata,
   input  wire [7:0]               i_rdata
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   reg  [1:0] sclk_sync_reg;
   reg  [1:0] csb_sync_reg;
   reg  [1:0] sdi_sync_reg;
   reg        sclk_prev_reg;
   reg  [4:0] bit_cnt_reg;
   reg  [15:0] shift_reg;
   reg  [7:0] tx_reg;
   reg        read_reg;
   reg        load_reg;
   wire       sclk_rise;
   wire       sclk_fall;
   wire       sel;
   wire [15:0] shift_next;

   assign sclk_rise  = sclk_sync_reg[1] & ~sclk_prev_reg;
   assign sclk_fall  = ~sclk_sync_reg[1] & sclk_prev_reg;
   assign sel        = ~csb_sync_reg[1];
   assign shift_next = {shift_reg[14:0], sdi_sync_reg[1]};

   always @(posedge i_core_clk) begin
      sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
      csb_sync_reg  <= {csb_sync_reg[0], i_csb_n};
      sdi_sync_reg  <= {sdi_sync_reg[0], i_sdio};
      sclk_prev_reg <= sclk_sync_reg[1];
   end

   // ****************************************************************
   // Frame engine
   // ****************************************************************
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         bit_cnt_reg <= 5'h00;
         shift_reg   <= 16'h0000;
         tx_reg      <= 8'h00;
         read_reg    <= 1'b0;
         load_reg    <= 1'b0;
         o_sdio      <= 1'b0;
         o_sdio_oe_n <= 1'b1;
         o_wr_stb    <= 1'b0;
         o_rd_stb    <= 1'b0;
         o_addr      <= {`SCM_ADDR_W{1'b0}};
         o_wdata     <= 8'h00;
      end else begin
         o_wr_stb <= 1'b0;
         o_rd_stb <= 1'b0;
         load_reg <= o_rd_stb;
         if (load_reg) begin
            tx_reg <= i_rdata;
         end
         if (!sel) begin
            bit_cnt_reg <= 5'h00;
            read_reg    <= 1'b0;
            o_sdio_oe_n <= 1'b1;
         end else if (sclk_rise && bit_cnt_reg != `SCM_FRAME_DONE) begin
            shift_reg   <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            if (bit_cnt_reg == `SCM_INSTR_LAST) begin
               read_reg <= shift_next[15];
               o_addr   <= shift_next[14:0];
               o_rd_stb <= shift_next[15];
            end
            if (bit_cnt_reg == `SCM_DATA_LAST && !read_reg) begin
               o_wdata  <= shift_next[7:0];
               o_wr_stb <= 1'b1;
            end
         end else if (sclk_fall && read_reg) begin
            if (bit_cnt_reg == `SCM_FRAME_DONE) begin
               o_sdio_oe_n <= 1'b1;
            end else begin
               o_sdio_oe_n <= 1'b0;
               o_sdio      <= tx_reg[7];
               tx_reg      <= {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

endmodule
`default_nettype wire

// [hdl/scm_sync_capture.v]
// Reference capture: skip counting, phase latch, counter, timestamp
`default_nettype none

module scm_sync_capture (
   input  wire        i_core_clk,
   input  wire        i_rst,
   input  wire        i_ref_edge,
   input  wire        i_counted_mode,
   input  wire        i_arm,
   input  wire [3:0]  i_skip,
   input  wire [3:0]  i_div_phase,
   input  wire        i_ts_enable,
   input  wire [6:0]  i_ts_delay,
   output reg         o_capture,
   output reg  [3:0]  o_phase,
   output reg  [7:0]  o_count,
   output reg         o_timestamp
);

   reg  [3:0] skip_left_reg;
   reg        armed_reg;
   reg  [6:0] ts_cnt_reg;
   reg        ts_busy_reg;
   reg        cap_now;

   // ****************************************************************
   // Capture decision
   // ****************************************************************
   always @* begin
      cap_now = 1'b0;
      if (i_ref_edge) begin
         if (!i_counted_mode) begin
            cap_now = 1'b1;
         end else if (armed_reg && skip_left_reg == 4'h0) begin
            cap_now = 1'b1;
         end
      end
   end

   always @(posedge i_core_clk) begin
      if (i_rst) begin
         skip_left_reg <= 4'h0;
         armed_reg     <= 1'b1;
         ts_cnt_reg    <= 7'h00;
         ts_busy_reg   <= 1'b0;
         o_capture     <= 1'b0;
         o_phase       <= 4'h0;
         o_count       <= 8'h00;
         o_timestamp   <= 1'b0;
      end else begin
         o_capture   <= cap_now;
         o_timestamp <= 1'b0;
         if (i_arm) begin
            skip_left_reg <= i_skip;
            armed_reg     <= 1'b1;
         end else if (i_ref_edge && i_counted_mode && armed_reg) begin
            if (skip_left_reg == 4'h0) begin
               armed_reg <= 1'b0;
            end else begin
               skip_left_reg <= skip_left_reg - 4'h1;
            end
         end
         if (cap_now) begin
            o_phase <= i_div_phase;
            o_count <= o_count + 8'h01;
         end
         // ****************************************************************
         // Timestamp delay
         // ****************************************************************
         if (cap_now) begin
            ts_busy_reg <= 1'b1;
            ts_cnt_reg  <= i_ts_enable ? i_ts_delay : 7'h00;
         end else if (ts_busy_reg) begin
            if (ts_cnt_reg == 7'h00) begin
               o_timestamp <= 1'b1;
               ts_busy_reg <= 1'b0;
            end else begin
               ts_cnt_reg <= ts_cnt_reg - 7'h01;
            end
         end
      end
   end

endmodule
`default_nettype wire

// [hdl/scm_sync_mode_regs.v]
// Capture and chip mode registers with serial port and sample path
`default_nettype none
`include "scm_defs.vh"

module scm_sync_mode_regs #(
   parameter SAMP_W = 14
) (
   input  wire                i_core_clk,
   input  wire                i_rst,
   input  wire                i_sclk,
   input  wire                i_csb_n,
   input  wire                i_sdio,
   output wire                o_sdio,
   output wire                o_sdio_oe_n,
   input  wire                i_sysref,
   input  wire                i_counted_mode,
   input  wire [3:0]          i_div_phase,
   input  wire [7:0]          i_window_status,
   input  wire                i_samp_valid,
   input  wire [SAMP_W-1:0]   i_samp_i,
   input  wire [SAMP_W-1:0]   i_samp_q,
   output reg                 o_samp_valid,
   output reg  [SAMP_W-1:0]   o_samp_i,
   output reg  [SAMP_W-1:0]   o_samp_q,
   output reg                 o_q_valid,
   output reg  [3:0]          o_ddc_enable,
   output reg                 o_full_bandwidth,
   output wire                o_capture,
   output wire                o_timestamp
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   wire                    wr_stb;
   wire                    rd_stb;
   wire [`SCM_ADDR_W-1:0]  addr;
   wire [7:0]              wdata;
   reg  [7:0]              rdata;

   reg  [3:0]              skip_reg;
   reg  [6:0]              ts_delay_reg;
   reg  [1:0]              sync_mode_reg;
   reg  [1:0]              op_mode_reg;
   reg                     qdrop_reg;
   reg  [2:0]              decim_reg;
   reg  [7:0]              offset_reg;
   reg                     arm_reg;

   reg  [1:0]              ref_sync_reg;
   reg                     ref_prev_reg;
   wire                    ref_edge;

   wire [3:0]              phase;
   wire [7:0]              count;
   wire                    ts_enable;

   reg  [2:0]              dec_cnt_reg;
   reg  [2:0]              dec_mask;
   wire [SAMP_W-1:0]       trim_i;
   wire [SAMP_W-1:0]       trim_q;

   // ****************************************************************
   // Serial control port
   // ****************************************************************
   scm_spi_slave u_spi (
      .i_core_clk  (i_core_clk),
      .i_rst       (i_rst),
      .i_sclk      (i_sclk),
      .i_csb_n     (i_csb_n),
      .i_sdio      (i_sdio),
      .o_sdio      (o_sdio),
      .o_sdio_oe_n (o_sdio_oe_n),
      .o_wr_stb    (wr_stb),
      .o_rd_stb    (rd_stb),
      .o_addr      (addr),
      .o_wdata     (wdata),
      .i_rdata     (rdata)
   );

   // ****************************************************************
   // Register writes
   // ****************************************************************
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         skip_reg      <= `SCM_RST_SKIP;
         ts_delay_reg  <= `SCM_RST_TS_DELAY;
         sync_mode_reg <= `SCM_RST_SYNC_MODE;
         op_mode_reg   <= `SCM_RST_OP_MODE;
         qdrop_reg     <= `SCM_RST_QDROP;
         decim_reg     <= `SCM_RST_DECIM;
         offset_reg    <= `SCM_RST_OFFSET;
         arm_reg       <= 1'b0;
      end else begin
         arm_reg <= 1'b0;
         if (wr_stb) begin
            case (addr)
               `SCM_ADDR_SKIP: begin
                  skip_reg <= wdata[3:0];
                  arm_reg  <= 1'b1;
               end
               `SCM_ADDR_TS_DELAY: begin
                  ts_delay_reg <= wdata[6:0];
               end
               `SCM_ADDR_SYNC_MODE: begin
                  sync_mode_reg <= wdata[1:0];
               end
               `SCM_ADDR_APP_MODE: begin
                  qdrop_reg   <= wdata[`SCM_APP_QDROP_BIT];
                  op_mode_reg <= wdata[1:0];
               end
               `SCM_ADDR_DECIM: begin
                  decim_reg <= wdata[2:0];
               end
               `SCM_ADDR_OFFSET: begin
                  offset_reg <= wdata;
               end
               default: begin
                  arm_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Register reads
   // ****************************************************************
   always @* begin
      case (addr)
         `SCM_ADDR_SKIP:       rdata = {4'h0, skip_reg};
         `SCM_ADDR_TS_DELAY:   rdata = {1'b0, ts_delay_reg};
         `SCM_ADDR_WIN_STATUS: rdata = i_window_status;
         `SCM_ADDR_PHASE:      rdata = {4'h0, phase};
         `SCM_ADDR_CAP_COUNT:  rdata = count;
         `SCM_ADDR_SYNC_MODE:  rdata = {6'h00, sync_mode_reg};
         `SCM_ADDR_APP_MODE:
            rdata = {2'h0, qdrop_reg, 3'h0, op_mode_reg};
         `SCM_ADDR_DECIM:      rdata = {5'h00, decim_reg};
         `SCM_ADDR_OFFSET:     rdata = offset_reg;
         default:              rdata = 8'h00;
      endcase
   end

   // ****************************************************************
   // Reference pin synchroniser and edge detect
   // ****************************************************************
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         ref_sync_reg <= 2'h0;
         ref_prev_reg <= 1'b0;
      end else begin
         ref_sync_reg <= {ref_sync_reg[0], i_sysref};
         ref_prev_reg <= ref_sync_reg[1];
      end
   end

   assign ref_edge  = ref_sync_reg[1] & ~ref_prev_reg;
   assign ts_enable = (sync_mode_reg == `SCM_SYNC_TIMESTAMP);

   // ****************************************************************
   // Capture engine
   // ****************************************************************
   scm_sync_capture u_cap (
      .i_core_clk     (i_core_clk),
      .i_rst          (i_rst),
      .i_ref_edge     (ref_edge),
      .i_counted_mode (i_counted_mode),
      .i_arm          (arm_reg),
      .i_skip         (skip_reg),
      .i_div_phase    (i_div_phase),
      .i_ts_enable    (ts_enable),
      .i_ts_delay     (ts_delay_reg),
      .o_capture      (o_capture),
      .o_phase        (phase),
      .o_count        (count),
      .o_timestamp    (o_timestamp)
   );

   // ****************************************************************
   // Offset trim with saturation
   // ****************************************************************
   function [SAMP_W-1:0] trim;
      input [SAMP_W-1:0] samp;
      input [7:0]        off;
      reg   [SAMP_W:0]   sum;
      begin
         sum = {samp[SAMP_W-1], samp}
             + {{(SAMP_W-7){off[7]}}, off};
         if (sum[SAMP_W] != sum[SAMP_W-1]) begin
            trim = {sum[SAMP_W], {(SAMP_W-1){~sum[SAMP_W]}}};
         end else begin
            trim = sum[SAMP_W-1:0];
         end
      end
   endfunction

   assign trim_i = trim(i_samp_i, offset_reg);
   assign trim_q = trim(i_samp_q, offset_reg);

   // ****************************************************************
   // Decimation ratio
   // ****************************************************************
   always @* begin
      case (decim_reg)
         `SCM_DEC_1: dec_mask = 3'h0;
         `SCM_DEC_2: dec_mask = 3'h1;
         `SCM_DEC_4: dec_mask = 3'h3;
         `SCM_DEC_8: dec_mask = 3'h7;
         default:    dec_mask = 3'h0;
      endcase
   end

   // ****************************************************************
   // Output sample path
   // ****************************************************************
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         dec_cnt_reg  <= 3'h0;
         o_samp_valid <= 1'b0;
         o_samp_i     <= {SAMP_W{1'b0}};
         o_samp_q     <= {SAMP_W{1'b0}};
         o_q_valid    <= 1'b0;
      end else begin
         o_samp_valid <= 1'b0;
         o_q_valid    <= 1'b0;
         if (i_samp_valid) begin
            dec_cnt_reg <= (dec_cnt_reg + 3'h1) & dec_mask;
            if (dec_cnt_reg == 3'h0) begin
               o_samp_valid <= 1'b1;
               o_samp_i     <= trim_i;
               if (qdrop_reg) begin
                  o_samp_q <= {SAMP_W{1'b0}};
               end else begin
                  o_samp_q  <= trim_q;
                  o_q_valid <= 1'b1;
               end
            end
         end
      end
   end

   // ****************************************************************
   // Operating mode decode
   // ****************************************************************
   always @(posedge i_core_clk) begin
      if (i_rst) begin
         o_ddc_enable     <= 4'h0;
         o_full_bandwidth <= 1'b1;
      end else begin
         o_full_bandwidth <= (op_mode_reg == `SCM_OP_FULL_BW);
         case (op_mode_reg)
            `SCM_OP_DDC0:    o_ddc_enable <= 4'h1;
            `SCM_OP_DDC01:   o_ddc_enable <= 4'h3;
            `SCM_OP_DDC0123: o_ddc_enable <= 4'hF;
            default:         o_ddc_enable <= 4'h0;
         endcase
      end
   end

endmodule
`default_nettype wire

// [verification/scm_sync_mode_regs_sva.sv]
// Concurrent checks on the capture and chip mode register ports
`default_nettype none
module scm_sync_mode_regs_sva #(
   parameter SAMP_W = 14
) (
   input wire logic              i_core_clk,
   input wire logic              i_rst,
   input wire logic              i_sysref,
   input wire logic              i_counted_mode,
   input wire logic              i_samp_valid,
   input wire logic              o_samp_valid,
   input wire logic [SAMP_W-1:0] o_samp_q,
   input wire logic              o_q_valid,
   input wire logic [3:0]        o_ddc_enable,
   input wire logic              o_full_bandwidth,
   input wire logic              o_capture,
   input wire logic              o_timestamp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] since_cap;
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   // ********
   // Cycles since the last capture
   // ********
   always @(posedge i_core_clk) begin
      if (i_rst)
         since_cap <= 8'hFF;
      else if (o_capture)
         since_cap <= 8'h00;
      else if (since_cap != 8'hFF)
         since_cap <= since_cap + 8'h01;
   end
   sequence s_free_rise;
      $rose(i_sysref) && !i_counted_mode;
   endsequence
   sequence s_capture_soon;
      ##[1:6] o_capture;
   endsequence
   property p_free_capture;
      s_free_rise |-> s_capture_soon;
   endproperty
   property p_cap_pulse;
      o_capture |=> !o_capture;
   endproperty
   property p_ts_delay;
      o_timestamp |-> since_cap <= 8'h7F;
   endproperty
   property p_q_follow;
      o_q_valid |-> o_samp_valid;
   endproperty
   property p_q_zero;
      o_samp_valid && !o_q_valid |-> o_samp_q == '0;
   endproperty
   property p_full_bw;
      o_full_bandwidth |-> o_ddc_enable == 4'h0;
   endproperty
   property p_ddc_set;
      !o_full_bandwidth |-> o_ddc_enable inside {4'h1, 4'h3, 4'hF};
   endproperty
   property p_out_cause;
      o_samp_valid |-> $past(i_samp_valid);
   endproperty
   a_free_capture: assert property (p_free_capture)
      else $error("reference edge not captured");
   a_cap_pulse: assert property (p_cap_pulse)
      else $error("capture pulse too long");
   a_ts_delay: assert property (p_ts_delay)
      else $error("timestamp too late after capture");
   a_q_follow: assert property (p_q_follow)
      else $error("quadrature valid without sample");
   a_q_zero: assert property (p_q_zero)
      else $error("dropped quadrature not zero");
   a_full_bw: assert property (p_full_bw)
      else $error("downconverter on in full bandwidth");
   a_ddc_set: assert property (p_ddc_set)
      else $error("illegal downconverter set");
   a_out_cause: assert property (p_out_cause)
      else $error("output sample without input");
endmodule
bind scm_sync_mode_regs scm_sync_mode_regs_sva #(.SAMP_W(SAMP_W)) chk_u (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_sysref(i_sysref),
   .i_counted_mode(i_counted_mode), .i_samp_valid(i_samp_valid),
   .o_samp_valid(o_samp_valid), .o_samp_q(o_samp_q),
   .o_q_valid(o_q_valid), .o_ddc_enable(o_ddc_enable),
   .o_full_bandwidth(o_full_bandwidth), .o_capture(o_capture),
   .o_timestamp(o_timestamp));
`default_nettype wire

// [verification/scm_sync_mode_regs_bench.sv]
// Self-checking bench for the capture and chip mode register group
`default_nettype none
`include "scm_defs.vh"
module scm_sync_mode_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam integer SW = 14;
   localparam integer MX = (1 << (SW - 1)) - 1;
   logic          clk = 0, rst = 1, sclk = 0, csb_n = 1, m_sdio = 0;
   logic          sysref = 0, cmode = 0, sv = 0;
   logic [3:0]    phase = 4'h0;
   logic [7:0]    win = 8'h00, rd = 8'h00, off;
   logic [SW-1:0] si = '0, sq = '0, a;
   wire           sdio, sdo, oe_n, osv, oqv, ofb, ocap, ots;
   wire  [SW-1:0] oi, oq;
   wire  [3:0]    ddc;
   logic [14:0]   ra [0:5] = '{`SCM_ADDR_SKIP, `SCM_ADDR_TS_DELAY,
      `SCM_ADDR_SYNC_MODE, `SCM_ADDR_APP_MODE, `SCM_ADDR_DECIM,
      `SCM_ADDR_OFFSET};
   logic [7:0]    rm [0:5] = '{8'h0F, 8'h7F, 8'h03, 8'h23, 8'h07, 8'hFF};
   logic [3:0]    de [0:3] = '{4'h0, 4'h1, 4'h3, 4'hF};
   integer        seed = 32'h3d2e7531, bad_count = 0, comparisons = 0;
   integer        cyc = 0, ncap = 0, gap = 0, ts_gap = 0, nout = 0;
   integer        i, k, n, m, ce = 0;
   assign sdio = oe_n ? m_sdio : sdo;
   always #2 clk = ~clk;
   scm_sync_mode_regs #(.SAMP_W(SW)) dut_u (
      .i_core_clk(clk), .i_rst(rst), .i_sclk(sclk), .i_csb_n(csb_n),
      .i_sdio(sdio), .o_sdio(sdo), .o_sdio_oe_n(oe_n), .i_sysref(sysref),
      .i_counted_mode(cmode), .i_div_phase(phase), .i_window_status(win),
      .i_samp_valid(sv), .i_samp_i(si), .i_samp_q(sq), .o_samp_valid(osv),
      .o_samp_i(oi), .o_samp_q(oq), .o_q_valid(oqv), .o_ddc_enable(ddc),
      .o_full_bandwidth(ofb), .o_capture(ocap), .o_timestamp(ots));
   // ********
   // Checking and closing
   // ********
   task end_of_test;
      begin
         if (bad_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk_reg(input [7:0] got, input [7:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_samp(input [SW-1:0] got, input [SW-1:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   function [SW-1:0] trim(input [SW-1:0] s, input [7:0] o);
      integer t;
      begin
         t = $signed(s) + $signed(o);
         if (t > MX)
            t = MX;
         if (t < -MX - 1)
            t = -MX - 1;
         trim = t[SW-1:0];
      end
   endfunction
   always @(posedge clk) begin
      cyc <= cyc + 1;
      gap <= ocap ? 1 : gap + 1;
      if (ots)
         ts_gap <= gap;
      if (ocap)
         ncap <= ncap + 1;
      if (osv)
         nout <= nout + 1;
      if (cyc == 60000) begin
         bad_count = bad_count + 1;
         end_of_test;
      end
   end
   // ********
   // Drivers
   // ********
   task spi(input rw, input [14:0] ad, input [7:0] wd);
      logic [23:0] f;
      integer j;
      begin
         f = {rw, ad, wd};
         @(posedge clk) csb_n <= 1'b0;
         for (j = 23; j >= 0; j = j - 1) begin
            repeat (6) @(posedge clk);
            sclk <= 1'b0;
            m_sdio <= (rw && j < 8) ? ~m_sdio : f[j];
            repeat (6) @(posedge clk);
            if (j < 8)
               rd = {rd[6:0], sdio};
            sclk <= 1'b1;
         end
         repeat (6) @(posedge clk);
         csb_n <= 1'b1;
         sclk <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask
   task rchk(input [14:0] ad, input [7:0] exp);
      begin
         spi(1'b1, ad, 8'h00);
         chk_reg(rd, exp);
      end
   endtask
   task pulse(input [3:0] ph);
      begin
         @(posedge clk) phase <= ph;
         sysref <= 1'b1;
         repeat (8) @(posedge clk);
         sysref <= 1'b0;
         repeat (8) @(posedge clk);
      end
   endtask
   task samp(input [SW-1:0] x, input [SW-1:0] y, input qd);
      begin
         @(posedge clk) sv <= 1'b1;
         si <= x;
         sq <= y;
         @(posedge clk) sv <= 1'b0;
         @(negedge clk);
         if (osv === 1'b1) begin
            chk_samp(oi, trim(x, off));
            chk_samp(oq, qd ? {SW{1'b0}} : trim(y, off));
            chk_reg(oqv, !qd);
         end
      end
   endtask
   // ********
   // Scenarios
   // ********
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      win <= $random(seed);
      repeat (6) @(posedge clk);
      chk_reg(ddc, 8'h00);
      chk_reg(ofb, 8'h01);
      for (i = 0; i < 6; i = i + 1)
         rchk(ra[i], 8'h00);
      rchk(`SCM_ADDR_CAP_COUNT, 8'h00);
      rchk(`SCM_ADDR_PHASE, 8'h00);
      rchk(`SCM_ADDR_WIN_STATUS, win);
      spi(1'b0, 15'h0122, 8'hA5);
      rchk(15'h0122, 8'h00);
      spi(1'b0, `SCM_ADDR_CAP_COUNT, 8'h5A);
      rchk(`SCM_ADDR_CAP_COUNT, 8'h00);
      for (i = 0; i < 6; i = i + 1) begin
         n = $random(seed);
         spi(1'b0, ra[i], n[7:0]);
         rchk(ra[i], n[7:0] & rm[i]);
      end
      for (i = 0; i < 4; i = i + 1) begin
         spi(1'b0, `SCM_ADDR_APP_MODE, i[7:0]);
         chk_reg(ddc, de[i]);
         chk_reg(ofb, i == 0);
      end
      for (k = 0; k < 8; k = k + 1) begin
         n = $random(seed);
         off = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : n[7:0];
         spi(1'b0, `SCM_ADDR_DECIM, {6'h00, k[2:1]});
         spi(1'b0, `SCM_ADDR_APP_MODE, {2'h0, k[0], 5'h00});
         spi(1'b0, `SCM_ADDR_OFFSET, off);
         nout = 0;
         for (i = 0; i < 16; i = i + 1) begin
            n = $random(seed);
            m = $random(seed);
            a = (i < 2) ? {i[0], {(SW - 1){~i[0]}}} : n[SW-1:0];
            samp(a, m[SW-1:0], k[0]);
            chk_reg(osv, (i % (1 << k[2:1])) == 0);
         end
         repeat (2) @(posedge clk);
         chk_reg(nout[7:0], 8'h10 >> k[2:1]);
      end
      m = ncap;
      for (i = 0; i < 3; i = i + 1)
         pulse($random(seed));
      ce = 3;
      chk_reg(ncap - m, 8'h03);
      rchk(`SCM_ADDR_PHASE, {4'h0, phase});
      rchk(`SCM_ADDR_CAP_COUNT, ce[7:0]);
      cmode <= 1'b1;
      for (k = 0; k < 3; k = k + 1) begin
         n = (k == 2) ? 15 : k * 2;
         spi(1'b0, `SCM_ADDR_SKIP, n[7:0]);
         m = ncap;
         for (i = 0; i < n + 3; i = i + 1)
            pulse(i[3:0]);
         ce = ce + 1;
         chk_reg(ncap - m, 8'h01);
         rchk(`SCM_ADDR_PHASE, n[7:0]);
         rchk(`SCM_ADDR_CAP_COUNT, ce[7:0]);
      end
      cmode <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
         n = $random(seed);
         n = (k == 0) ? 5 : (k == 1) ? 0 : (k == 2) ? 127 : n & 127;
         spi(1'b0, `SCM_ADDR_TS_DELAY, n[7:0]);
         spi(1'b0, `SCM_ADDR_SYNC_MODE, {7'h00, k != 0});
         ts_gap = 0;
         pulse(4'h0);
         repeat (140) @(posedge clk);
         chk_reg(ts_gap[7:0], (k == 0) ? 8'h01 : n[7:0] + 8'h01);
      end
      rchk(`SCM_ADDR_CAP_COUNT, ce[7:0] + 8'h04);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      chk_reg(ofb, 8'h01);
      rchk(`SCM_ADDR_CAP_COUNT, 8'h00);
      rchk(`SCM_ADDR_OFFSET, 8'h00);
      end_of_test;
   end
endmodule
`default_nettype wire
